// File: common/ipd_regs.svh
`ifndef IPD_REGS_SVH
`define IPD_REGS_SVH

// Prefix byte that selects the second opcode page
`define IPD_PAGE2_PREFIX    8'h18

// Base register selector codes
`define IPD_SEL_X           2'h0
`define IPD_SEL_Y           2'h1
`define IPD_SEL_SP          2'h2
`define IPD_SEL_PC          2'h3

// Accumulator selector codes in the 111rr1aa form
`define IPD_ACC_A           2'h0
`define IPD_ACC_B           2'h1
`define IPD_ACC_D           2'h2
`define IPD_ACC_D_IND       2'h3

// Postbyte field positions
`define IPD_XB_LONG_BIT     5
`define IPD_XB_LONG_TAG     3'h7
`define IPD_XB_ACC_BIT      2
`define IPD_XB_SIZE_BIT     1
`define IPD_XB_SIGN_BIT     0
`define IPD_XB_POST_BIT     4
`define IPD_XB_NEG_BIT      3

// Extension byte counts
`define IPD_EXT_NONE        2'h0
`define IPD_EXT_ONE         2'h1
`define IPD_EXT_TWO         2'h2

// Reset values
`define IPD_RST_BYTE        8'h00
`define IPD_RST_WORD        16'h0000

`endif

// File: common/ipd_pkg.sv
`default_nettype none

package ipd_pkg;

    // Decoder sequencer states, one-hot
    typedef enum logic [4:0] {
        st_opcode   = 5'h01,
        st_postbyte = 5'h02,
        st_ext      = 5'h04,
        st_add      = 5'h08,
        st_ptr      = 5'h10
    } ipd_state_type;

    // Opcode map answer for the byte in opcode position
    typedef enum logic [1:0] {
        op_plain    = 2'h0,
        op_indexed  = 2'h1,
        op_postbyte = 2'h2,
        op_reserved = 2'h3
    } ipd_op_class_type;

    // Source of the indexed offset
    typedef enum logic [1:0] {
        off_none  = 2'h0,
        off_const = 2'h1,
        off_accum = 2'h2,
        off_step  = 2'h3
    } ipd_off_kind_type;

    // Indexed addressing form
    typedef enum logic [2:0] {
        mode_none             = 3'h0,
        indexed_short_mode    = 3'h1,
        indexed_one_ext_mode  = 3'h2,
        indexed_two_ext_mode  = 3'h3,
        two_ext_indirect_mode = 3'h4,
        accum_d_indirect_mode = 3'h5
    } ipd_mode_type;

    // Whole state of the decoder
    typedef struct packed {
        ipd_state_type    state;
        logic             ready;
        logic             page2_pend;
        logic             page2;
        logic [7:0]       opcode;
        logic [7:0]       postbyte;
        logic             is_idx;
        logic [1:0]       ext_left;
        logic [1:0]       ext_total;
        logic [15:0]      ext_word;
        ipd_off_kind_type kind;
        ipd_mode_type     mode;
        logic [1:0]       base_sel;
        logic [1:0]       acc_sel;
        logic [15:0]      base_val;
        logic [15:0]      off_val;
        logic             step_en;
        logic             step_post;
        logic [15:0]      step_amt;
        logic             indirect;
        logic [15:0]      ea;
        logic             ptr_req;
        logic [15:0]      operand;
        logic             done;
    } ipd_core_type;

endpackage : ipd_pkg

`default_nettype wire

// File: rtl/ipd_ea_adder.sv
`default_nettype none

// Address adder; the sum wraps at the word width
module ipd_ea_adder #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] i_base,
    input  wire logic [WIDTH-1:0] i_offset,
    output logic      [WIDTH-1:0] o_sum
);

    // Carry out is dropped on purpose: modulo arithmetic
    assign o_sum = i_base + i_offset;

endmodule : ipd_ea_adder

`default_nettype wire

// File: rtl/ipd_decoder.sv
// Overview of operation
// - Indexed instruction is opcode, one postbyte, then zero to two extension bytes.
// - Postbyte rr0nnnnn gives signed 5-bit offset -16..+15, no extension.
// - Selector picks X, Y, stack pointer or program counter as base.
// - Postbyte 111rr0zs: size 0 is 9-bit one byte, 1 is 16-bit two bytes.
// - Nine-bit offset takes sign from postbyte bit 0, low byte from extension.
// - Postbyte 111rr011 is 16-bit offset indirect with two extension bytes.
// - Postbyte rr1pnnnn auto-steps base; p=0 pre, 1 post; step -8..-1, +1..+8.
// - Auto-step base is X, Y or stack pointer only, never program counter.
// - Postbyte 111rr1aa: 00 is A, 01 is B, 10 is D, all unsigned.
// - Postbyte 111rr111 adds D to base to locate pointer, no extension.
// - Each opcode names instruction and addressing mode together.
// - Prefix 18 in opcode position selects second page for next byte.
// - Accept postbytes and address, offset or immediate extension bytes.
// - Effective address is base register plus selected offset.
// - Indirect forms fetch a 16-bit pointer that becomes the operand address.

`include "ipd_regs.svh"

`default_nettype none

module ipd_decoder (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_nrst,
    // Byte stream from the fetch queue
    input  wire logic                      i_byte_valid,
    input  wire logic [7:0]                i_byte,
    output logic                           o_byte_ready,
    // Opcode map answer for i_byte while o_at_opcode is high
    output logic                           o_at_opcode,
    output logic                           o_page2_pend,
    input  wire ipd_pkg::ipd_op_class_type i_op_class,
    input  wire logic [1:0]                i_op_ext_cnt,
    // Core register file
    input  wire logic [15:0]               i_reg_x,
    input  wire logic [15:0]               i_reg_y,
    input  wire logic [15:0]               i_reg_sp,
    input  wire logic [15:0]               i_reg_pc,
    input  wire logic [7:0]                i_acc_a,
    input  wire logic [7:0]                i_acc_b,
    // Pointer fetch for indirect forms
    output logic                           o_ptr_req,
    output logic [15:0]                    o_ptr_addr,
    input  wire logic                      i_ptr_valid,
    input  wire logic [15:0]               i_ptr_data,
    // Decoded instruction, valid with o_done
    output logic                           o_done,
    output logic                           o_page2,
    output logic [7:0]                     o_opcode,
    output logic [7:0]                     o_postbyte,
    output logic                           o_is_indexed,
    output logic [1:0]                     o_ext_count,
    output logic [15:0]                    o_ext_word,
    output ipd_pkg::ipd_off_kind_type      o_off_kind,
    output ipd_pkg::ipd_mode_type          o_mode,
    output logic [1:0]                     o_base_sel,
    output logic [1:0]                     o_acc_sel,
    output logic                           o_indirect,
    output logic                           o_step_en,
    output logic                           o_step_post,
    output logic [15:0]                    o_step_amt,
    output logic [15:0]                    o_ea,
    output logic [15:0]                    o_operand_addr
);

    import ipd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State and adder

    ipd_core_type s;
    ipd_core_type next_s;
    logic         take;
    logic [15:0]  sum;

    // Byte handshake
    assign take = i_byte_valid & s.ready;

    // Base plus offset, computed one cycle after operands are latched
    ipd_ea_adder #(
        .WIDTH    (16)
    ) u_adder (
        .i_base   (s.base_val),
        .i_offset (s.off_val),
        .o_sum    (sum)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Value of the selected base register
    function automatic logic [15:0] base_of(input logic [1:0] sel);
        logic [15:0] v;
        v = i_reg_pc;
        unique case (sel)
            `IPD_SEL_X:  v = i_reg_x;
            `IPD_SEL_Y:  v = i_reg_y;
            `IPD_SEL_SP: v = i_reg_sp;
            `IPD_SEL_PC: v = i_reg_pc;
        endcase
        return v;
    endfunction : base_of

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        unique case (s.state)
            st_opcode: begin
                if (take) begin
                    if ((i_byte == `IPD_PAGE2_PREFIX) && !s.page2_pend) begin
                        // Prefix only arms the page; a second prefix is an opcode
                        next_s.page2_pend = 1'b1;
                    end else begin
                        next_s.opcode     = i_byte;
                        next_s.page2      = s.page2_pend;
                        next_s.page2_pend = 1'b0;
                        next_s.postbyte   = `IPD_RST_BYTE;
                        next_s.ext_word   = `IPD_RST_WORD;
                        next_s.kind       = off_none;
                        next_s.mode       = mode_none;
                        next_s.base_sel   = `IPD_SEL_X;
                        next_s.acc_sel    = `IPD_ACC_A;
                        next_s.step_en    = 1'b0;
                        next_s.step_post  = 1'b0;
                        next_s.step_amt   = `IPD_RST_WORD;
                        next_s.indirect   = 1'b0;
                        next_s.ea         = `IPD_RST_WORD;
                        next_s.operand    = `IPD_RST_WORD;
                        next_s.ext_left   = i_op_ext_cnt;
                        next_s.ext_total  = i_op_ext_cnt;
                        next_s.is_idx     = (i_op_class == op_indexed);
                        if (i_op_class == op_indexed || i_op_class == op_postbyte) begin
                            next_s.state = st_postbyte;
                        end else if (i_op_ext_cnt != `IPD_EXT_NONE) begin
                            next_s.state = st_ext;
                        end else begin
                            next_s.done = 1'b1;
                        end
                    end
                end
            end
            st_postbyte: begin
                if (take) begin
                    next_s.postbyte = i_byte;
                    if (!s.is_idx) begin
                        // Transfer, exchange or loop postbyte
                        if (s.ext_left == `IPD_EXT_NONE) begin
                            next_s.state = st_opcode;
                            next_s.done  = 1'b1;
                        end else begin
                            next_s.state = st_ext;
                        end
                    end else if (!i_byte[`IPD_XB_LONG_BIT]) begin
                        // Short constant offset held in the postbyte
                        next_s.base_sel  = i_byte[7:6];
                        next_s.base_val  = base_of(i_byte[7:6]);
                        next_s.off_val   = {{11{i_byte[4]}}, i_byte[4:0]};
                        next_s.kind      = off_const;
                        next_s.mode      = indexed_short_mode;
                        next_s.ext_left  = `IPD_EXT_NONE;
                        next_s.ext_total = `IPD_EXT_NONE;
                        next_s.state     = st_add;
                    end else if (i_byte[7:5] != `IPD_XB_LONG_TAG) begin
                        // Auto step; selector 11 lands in the long forms, so no PC here
                        next_s.base_sel  = i_byte[7:6];
                        next_s.base_val  = base_of(i_byte[7:6]);
                        next_s.step_en   = 1'b1;
                        next_s.step_post = i_byte[`IPD_XB_POST_BIT];
                        if (i_byte[`IPD_XB_NEG_BIT]) begin
                            next_s.step_amt = {{12{1'b1}}, i_byte[3:0]};
                        end else begin
                            next_s.step_amt = {12'h000, i_byte[3:0]} + 16'h0001;
                        end
                        // Pre-step addresses the stepped value, post-step the old one
                        if (i_byte[`IPD_XB_POST_BIT]) begin
                            next_s.off_val = `IPD_RST_WORD;
                        end else if (i_byte[`IPD_XB_NEG_BIT]) begin
                            next_s.off_val = {{12{1'b1}}, i_byte[3:0]};
                        end else begin
                            next_s.off_val = {12'h000, i_byte[3:0]} + 16'h0001;
                        end
                        next_s.kind      = off_step;
                        next_s.mode      = indexed_short_mode;
                        next_s.ext_left  = `IPD_EXT_NONE;
                        next_s.ext_total = `IPD_EXT_NONE;
                        next_s.state     = st_add;
                    end else if (!i_byte[`IPD_XB_ACC_BIT]) begin
                        // Long constant offset from extension bytes
                        next_s.base_sel = i_byte[4:3];
                        next_s.kind     = off_const;
                        next_s.state    = st_ext;
                        if (!i_byte[`IPD_XB_SIZE_BIT]) begin
                            next_s.mode      = indexed_one_ext_mode;
                            next_s.ext_left  = `IPD_EXT_ONE;
                            next_s.ext_total = `IPD_EXT_ONE;
                        end else begin
                            next_s.ext_left  = `IPD_EXT_TWO;
                            next_s.ext_total = `IPD_EXT_TWO;
                            next_s.indirect  = i_byte[`IPD_XB_SIGN_BIT];
                            next_s.mode      = i_byte[`IPD_XB_SIGN_BIT] ? two_ext_indirect_mode
                                                                        : indexed_two_ext_mode;
                        end
                    end else begin
                        // Accumulator offset, unsigned
                        next_s.base_sel  = i_byte[4:3];
                        next_s.base_val  = base_of(i_byte[4:3]);
                        next_s.acc_sel   = i_byte[1:0];
                        next_s.kind      = off_accum;
                        next_s.mode      = indexed_short_mode;
                        next_s.ext_left  = `IPD_EXT_NONE;
                        next_s.ext_total = `IPD_EXT_NONE;
                        next_s.state     = st_add;
                        unique case (i_byte[1:0])
                            `IPD_ACC_A: next_s.off_val = {8'h00, i_acc_a};
                            `IPD_ACC_B: next_s.off_val = {8'h00, i_acc_b};
                            `IPD_ACC_D: next_s.off_val = {i_acc_a, i_acc_b};
                            `IPD_ACC_D_IND: begin
                                next_s.off_val  = {i_acc_a, i_acc_b};
                                next_s.indirect = 1'b1;
                                next_s.mode     = accum_d_indirect_mode;
                            end
                        endcase
                    end
                end
            end
            st_ext: begin
                if (take) begin
                    // First byte is the high byte of a word
                    next_s.ext_word = {s.ext_word[7:0], i_byte};
                    next_s.ext_left = s.ext_left - 2'h1;
                    if (s.ext_left == `IPD_EXT_ONE) begin
                        if (s.is_idx) begin
                            next_s.base_val = base_of(s.base_sel);
                            next_s.state    = st_add;
                            if (s.mode == indexed_one_ext_mode) begin
                                // Sign from the postbyte, low bits from the extension
                                next_s.off_val = {{8{s.postbyte[`IPD_XB_SIGN_BIT]}}, i_byte};
                            end else begin
                                next_s.off_val = {s.ext_word[7:0], i_byte};
                            end
                        end else begin
                            next_s.state = st_opcode;
                            next_s.done  = 1'b1;
                        end
                    end
                end
            end
            st_add: begin
                // Wrapping add of base and offset
                next_s.ea = sum;
                if (s.indirect) begin
                    next_s.ptr_req = 1'b1;
                    next_s.state   = st_ptr;
                end else begin
                    next_s.operand = sum;
                    next_s.done    = 1'b1;
                    next_s.state   = st_opcode;
                end
            end
            st_ptr: begin
                // Fetched pointer becomes the operand address
                if (i_ptr_valid) begin
                    next_s.operand = i_ptr_data;
                    next_s.ptr_req = 1'b0;
                    next_s.done    = 1'b1;
                    next_s.state   = st_opcode;
                end
            end
        endcase
        // Bytes are held off while the address is being formed
        next_s.ready = (next_s.state != st_add) && (next_s.state != st_ptr);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s            <= '0;
            s.state      <= st_opcode;
            s.ready      <= 1'b1;
            s.kind       <= off_none;
            s.mode       <= mode_none;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign o_byte_ready   = s.ready;
    assign o_at_opcode    = s.state[0];
    assign o_page2_pend   = s.page2_pend;
    assign o_ptr_req      = s.ptr_req;
    assign o_ptr_addr     = s.ea;
    assign o_done         = s.done;
    assign o_page2        = s.page2;
    assign o_opcode       = s.opcode;
    assign o_postbyte     = s.postbyte;
    assign o_is_indexed   = s.is_idx;
    assign o_ext_count    = s.ext_total;
    assign o_ext_word     = s.ext_word;
    assign o_off_kind     = s.kind;
    assign o_mode         = s.mode;
    assign o_base_sel     = s.base_sel;
    assign o_acc_sel      = s.acc_sel;
    assign o_indirect     = s.indirect;
    assign o_step_en      = s.step_en;
    assign o_step_post    = s.step_post;
    assign o_step_amt     = s.step_amt;
    assign o_ea           = s.ea;
    assign o_operand_addr = s.operand;

endmodule : ipd_decoder

`default_nettype wire

// File: dv/ipd_decoder_chk.sv
`default_nettype none

module ipd_decoder_chk (
    input wire logic                      i_core_clk,
    input wire logic                      i_nrst,
    input wire logic                      i_ptr_valid,
    input wire logic [15:0]               i_ptr_data,
    input wire logic                      o_byte_ready,
    input wire logic                      o_ptr_req,
    input wire logic [15:0]               o_ptr_addr,
    input wire logic [15:0]               o_ea,
    input wire logic                      o_done,
    input wire logic                      o_is_indexed,
    input wire logic [7:0]                o_postbyte,
    input wire ipd_pkg::ipd_mode_type     o_mode,
    input wire ipd_pkg::ipd_off_kind_type o_off_kind,
    input wire logic [1:0]                o_ext_count,
    input wire logic [1:0]                o_base_sel,
    input wire logic                      o_indirect,
    input wire logic                      o_step_en,
    input wire logic [15:0]               o_operand_addr
);
    import ipd_pkg::*;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    // Indexed result, and a postbyte of the long 111rr family
    wire logic idx_done = o_done && o_is_indexed;
    wire logic long_pb  = o_postbyte[7:5] == 3'h7;

    ////////////////////////////////////////////////////////////////////////
    a_ptr_answer: assert property (o_ptr_req && i_ptr_valid |=>
        o_done && !o_ptr_req && o_operand_addr == $past(i_ptr_data)) else $error("pointer answer lost");
    a_ptr_hold: assert property (o_ptr_req |-> o_ptr_addr == o_ea && !o_byte_ready)
        else $error("pointer request not steady");
    a_ea_direct: assert property (idx_done && !o_indirect |-> o_operand_addr == o_ea)
        else $error("direct operand address differs");
    a_short_form: assert property (idx_done && !o_postbyte[5] |-> o_mode == indexed_short_mode &&
        o_off_kind == off_const && o_ext_count == 2'h0 && o_base_sel == o_postbyte[7:6])
        else $error("short constant form wrong");
    a_step_base: assert property (o_done && o_step_en |-> o_base_sel != 2'h3 && o_off_kind == off_step)
        else $error("auto step base wrong");
    a_long_size: assert property (idx_done && long_pb && !o_postbyte[2] |->
        o_ext_count == (o_postbyte[1] ? 2'h2 : 2'h1) && o_base_sel == o_postbyte[4:3])
        else $error("long constant size wrong");
    a_long_ind: assert property (idx_done && long_pb && o_postbyte[2:0] == 3'h3 |->
        o_mode == two_ext_indirect_mode && o_indirect) else $error("long indirect form wrong");
    a_d_indirect: assert property (idx_done && long_pb && o_postbyte[2:0] == 3'h7 |->
        o_mode == accum_d_indirect_mode && o_indirect && o_ext_count == 2'h0) else $error("D indirect form wrong");

    // Main traffic kinds reached
    cover property (o_ptr_req && i_ptr_valid);
    cover property (o_done && o_step_en);
    cover property (o_done && !o_is_indexed);
endmodule : ipd_decoder_chk

bind ipd_decoder ipd_decoder_chk u_chk (.*);

`default_nettype wire

// File: dv/ipd_ptr_model.sv
`default_nettype none

module ipd_ptr_model (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic [1:0]  i_delay,
    output logic             o_valid,
    output logic [15:0]      o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Pointer after a chosen wait; idle data churns so stale words fail
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_cnt <= 2'h0;
            o_valid  <= 1'b0;
            o_data   <= 16'h0000;
        end else if (i_req && !o_valid && wait_cnt >= i_delay) begin
            o_valid <= 1'b1;
            o_data  <= {i_addr[7:0], i_addr[15:8]} ^ 16'h0f0f;
        end else begin
            wait_cnt <= (i_req && !o_valid) ? wait_cnt + 2'h1 : 2'h0;
            o_valid  <= 1'b0;
            o_data   <= ~o_data;
        end
    end
endmodule : ipd_ptr_model

`default_nettype wire

// File: dv/tb_indexed_postbyte_decoder.sv
`default_nettype none

module tb_indexed_postbyte_decoder;
    import ipd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk = 1'b0, i_nrst, i_byte_valid, i_ptr_valid, o_byte_ready, o_at_opcode, o_page2_pend;
    logic o_ptr_req, o_done, o_page2, o_is_indexed, o_indirect, o_step_en, o_step_post;
    logic [7:0] i_byte, i_acc_a, i_acc_b, o_opcode, o_postbyte;
    logic [1:0] i_op_ext_cnt, ptr_delay, o_ext_count, o_base_sel, o_acc_sel;
    logic [15:0] i_reg_x, i_reg_y, i_reg_sp, i_reg_pc, i_ptr_data, o_ptr_addr, o_ext_word, o_step_amt;
    logic [15:0] o_ea, o_operand_addr;
    ipd_op_class_type i_op_class;
    ipd_off_kind_type o_off_kind;
    ipd_mode_type o_mode;
    int err_total = 0, check_count = 0;
    logic [31:0] lfsr_state = 32'h6131;
    logic [15:0] r;
    logic [7:0] pbs[13] = '{8'h10, 8'hcf, 8'h27, 8'h78, 8'hb4, 8'he0, 8'he9, 8'hfa, 8'he3, 8'hec, 8'hf5,
                            8'hf6, 8'hff};

    ipd_decoder DUT (.*);
    ipd_ptr_model u_ptr (.i_clk(i_core_clk), .i_nrst, .i_req(o_ptr_req), .i_addr(o_ptr_addr), .i_delay(ptr_delay),
        .o_valid(i_ptr_valid), .o_data(i_ptr_data));

    always #2 i_core_clk = ~i_core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic next_rand(output logic [15:0] v);
        repeat (16) lfsr_state = lfsr_state[0] ? (lfsr_state >> 1) ^ 32'h80200003 : lfsr_state >> 1;
        v = lfsr_state[15:0];
    endtask : next_rand

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Hold a byte until a ready edge takes it
    task automatic send_byte(input logic [7:0] b, input ipd_op_class_type cls, input logic [1:0] cnt);
        i_byte_valid = 1'b1;
        i_byte = b;
        i_op_class = cls;
        i_op_ext_cnt = cnt;
        for (int n = 0; n < 100 && !o_byte_ready; n++) @(negedge i_core_clk);
        @(negedge i_core_clk);
    endtask : send_byte

    // One instruction against the bench's own decode
    task automatic run_instr(input logic p2, input ipd_op_class_type cls, input logic [1:0] cnt,
                             input logic [7:0] pb);
        logic [15:0] e, base, off, ea;
        logic [7:0] op;
        logic [1:0] rr, ne;
        logic ind;
        ipd_mode_type md;
        ipd_off_kind_type kd;
        next_rand(i_reg_x);
        next_rand(i_reg_y);
        next_rand(i_reg_sp);
        next_rand(i_reg_pc);
        next_rand(e);
        next_rand(r);
        {i_acc_a, i_acc_b} = r;
        ptr_delay = r[9:8];
        op = e[7:0] ^ r[15:8];
        if (op == 8'h18) op = 8'h19;
        rr = pb[7:6];
        md = indexed_short_mode;
        kd = off_const;
        ne = 2'h0;
        ind = 1'b0;
        off = {{11{pb[4]}}, pb[4:0]};
        if (pb[7:5] == 3'h7) begin
            rr = pb[4:3];
            case (pb[2:0])
                3'h0, 3'h1: {md, ne, off} = {indexed_one_ext_mode, 2'h1, {8{pb[0]}}, e[15:8]};
                3'h2, 3'h3: {md, ne, off, ind} = {pb[0] ? two_ext_indirect_mode : indexed_two_ext_mode,
                                                  2'h2, e, pb[0]};
                3'h4: {kd, off} = {off_accum, 8'h00, i_acc_a};
                3'h5: {kd, off} = {off_accum, 8'h00, i_acc_b};
                3'h6: {kd, off} = {off_accum, i_acc_a, i_acc_b};
                default: {md, kd, off, ind} = {accum_d_indirect_mode, off_accum, i_acc_a, i_acc_b, 1'b1};
            endcase
        end else if (pb[5]) begin
            kd = off_step;
            off = pb[3] ? {12'hfff, pb[3:0]} : {12'h000, pb[3:0]} + 16'h1;
        end
        base = rr == 2'h0 ? i_reg_x : rr == 2'h1 ? i_reg_y : rr == 2'h2 ? i_reg_sp : i_reg_pc;
        ea = (kd == off_step && pb[4]) ? base : base + off;
        if (cls != op_indexed) ne = cnt;
        if (p2) begin
            send_byte(8'h18, op_plain, 2'h0);
            check(o_page2_pend, 1'b1);
        end
        send_byte(op, cls, cnt);
        if (cls == op_indexed || cls == op_postbyte) send_byte(pb, op_plain, 2'h0);
        if (ne != 2'h0) send_byte(e[15:8], op_plain, 2'h0);
        if (ne == 2'h2) send_byte(e[7:0], op_plain, 2'h0);
        i_byte_valid = 1'b0;
        i_byte = ~i_byte;
        for (int n = 0; n < 100 && !o_done; n++) @(negedge i_core_clk);
        check({o_done, o_at_opcode}, 2'h3);
        check(o_page2, p2);
        check(o_opcode, op);
        check(o_is_indexed, cls == op_indexed);
        check(o_ext_count, ne);
        if (ne != 2'h0) check(o_ext_word, ne == 2'h2 ? e : {8'h00, e[15:8]});
        if (cls == op_indexed || cls == op_postbyte) check(o_postbyte, pb);
        if (cls == op_indexed) begin
            check(o_mode, md);
            check(o_off_kind, kd);
            check(o_base_sel, rr);
            check(o_indirect, ind);
            check(o_ea, ea);
            check(o_operand_addr, ind ? {ea[7:0], ea[15:8]} ^ 16'h0f0f : ea);
            check(o_step_en, kd == off_step);
            if (kd == off_accum) check(o_acc_sel, pb[1:0]);
            if (kd == off_step) check({o_step_post, o_step_amt}, {pb[4], off});
        end
    endtask : run_instr

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Reset, every postbyte form, then a random stream
    initial begin
        {i_nrst, i_byte_valid, i_byte, i_op_ext_cnt, ptr_delay, i_acc_a, i_acc_b} = '0;
        {i_reg_x, i_reg_y, i_reg_sp, i_reg_pc} = '0;
        i_op_class = op_plain;
        repeat (3) @(negedge i_core_clk);
        check({o_byte_ready, o_at_opcode, o_done}, 3'h6);
        i_nrst = 1'b1;
        $display("reset done");
        foreach (pbs[i]) run_instr(i[0], op_indexed, 2'h0, pbs[i]);
        $display("forms done");
        repeat (150) begin
            next_rand(r);
            run_instr(r[8], ipd_op_class_type'(r[10:9]), r[12] ? 2'h2 : {1'b0, r[11]}, r[7:0] ^ r[15:8]);
        end
        $display("random done");
        test_done();
    end

    // Hang guard, far past the expected run
    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule : tb_indexed_postbyte_decoder

`default_nettype wire
